// ==== dbu_map.svh ====
// Register offsets, field positions, reset values and timing counts of the debug serial unit
`ifndef DBU_MAP_SVH
`define DBU_MAP_SVH
`define DBU_CR_OFS      8'h00
`define DBU_MR_OFS      8'h04
`define DBU_SR_OFS      8'h14
`define DBU_RHR_OFS     8'h18
`define DBU_THR_OFS     8'h1c
`define DBU_BRGR_OFS    8'h20
`define DBU_CIDR_OFS    8'h40
`define DBU_EXID_OFS    8'h44
`define DBU_FNR_OFS     8'h48
// Control register command bits
`define DBU_CR_RECEIVER_RESET_CMD    2
`define DBU_CR_RSTTX    3
`define DBU_CR_RECEIVE_ENABLE_CMD     4
`define DBU_CR_RECEIVE_DISABLE_CMD    5
`define DBU_CR_TXEN     6
`define DBU_CR_TXDIS    7
`define DBU_CR_RESET_STATUS_CMD   8
// Mode register fields
`define DBU_MR_PAR_LSB  9
`define DBU_MR_CHM_LSB  14
`define DBU_PAR_EVEN    3'h0
`define DBU_PAR_ODD     3'h1
`define DBU_PAR_SPACE   3'h2
`define DBU_PAR_MARK    3'h3
`define DBU_PAR_NONE_B  2
`define DBU_CHM_NORMAL  2'h0
`define DBU_CHM_ECHO    2'h1
`define DBU_CHM_LOCAL   2'h2
`define DBU_CHM_REMOTE  2'h3
// Status register bits
`define DBU_SR_RECEIVE_READY_FLAG    0
`define DBU_SR_TXRDY    1
`define DBU_SR_OVERRUN_FLAG     5
`define DBU_SR_FRAME    6
`define DBU_SR_PARITY_ERROR_FLAG     7
`define DBU_SR_TXEMPTY  9
`define DBU_SR_EMULATOR_CHANNEL_TX_FULL   30
`define DBU_SR_EMULATOR_CHANNEL_RX_FULL   31
// Reset values
`define DBU_MR_RST      16'h0000
`define DBU_DIV_RST     17'h00000
// Receiver timing in sampling ticks (counter value before the tick)
`define DBU_START_LAST  5'h06
`define DBU_SAMPLE_AT   5'h17
`define DBU_REBASE      5'h08
// Transmitter timing
`define DBU_TX_SUB_LAST 4'hf
`define DBU_TX_BITS_PAR 4'hb
`define DBU_TX_BITS_NOP 4'ha
`endif

// ==== dbu_pkg.sv ====
// Types and shared functions of the debug serial unit
package dbu_pkg;
  typedef enum logic [2:0] {RX_OFF, RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} dbu_rx_state_e;
  typedef enum logic       {TX_IDLE, TX_SEND} dbu_tx_state_e;
  typedef struct packed {
    logic enable;
    logic halt;
    logic reset;
  } dbu_rx_ctl_s;
  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
  } dbu_rx_char_s;
  // Parity bit for a character under a given parity mode (low two bits)
  function automatic logic dbu_parity(input logic [7:0] data, input logic [1:0] mode);
    case (mode)
      2'h0:    dbu_parity = ^data;
      2'h1:    dbu_parity = ~^data;
      2'h2:    dbu_parity = 1'b0;
      default: dbu_parity = 1'b1;
    endcase
  endfunction
endpackage

// ==== dbu_rx.sv ====
// Receiver of the debug serial unit: start qualification, mid-bit sampling, error flags
`timescale 1ns/10ps
`include "dbu_map.svh"
module dbu_rx import dbu_pkg::*; (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         tick,
  input  wire logic         line,
  input  wire dbu_rx_ctl_s  ctl,
  input  wire logic [2:0]   par_mode,
  output logic              done,
  output dbu_rx_char_s      chr
);
  dbu_rx_state_e state_reg;
  logic [4:0]    cnt_reg;
  logic [2:0]    bit_reg;
  logic [7:0]    shift_reg;
  logic          par_bad_reg;
  logic          stop_pend_reg;
  logic          samp;

  // Mid-bit sampling point
  assign samp = tick && (cnt_reg == `DBU_SAMPLE_AT);

  // Sampling tick counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 5'h00;
    end else if (ctl.reset || state_reg == RX_OFF || state_reg == RX_IDLE) begin
      cnt_reg <= 5'h00;
    end else if (samp) begin
      cnt_reg <= `DBU_REBASE;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // Receive state machine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= RX_OFF;
      bit_reg       <= 3'h0;
      shift_reg     <= 8'h00;
      par_bad_reg   <= 1'b0;
      stop_pend_reg <= 1'b0;
      done          <= 1'b0;
      chr           <= '0;
    end else begin
      done <= 1'b0;
      if (ctl.reset) begin
        state_reg     <= RX_OFF;
        stop_pend_reg <= 1'b0;
      end else begin
        if (ctl.enable) begin
          stop_pend_reg <= 1'b0;
        end else if (ctl.halt) begin
          stop_pend_reg <= 1'b1;
        end
        case (state_reg)
          RX_OFF: begin
            if (ctl.enable) begin
              state_reg <= RX_IDLE;
            end
          end
          RX_IDLE: begin
            if (ctl.halt && !ctl.enable) begin
              state_reg <= RX_OFF;
            end else if (tick && !line) begin
              state_reg <= RX_START;
            end
          end
          RX_START: begin
            if (ctl.halt && !ctl.enable) begin
              state_reg <= RX_OFF;
            end else if (tick && line) begin
              state_reg <= RX_IDLE;
            end else if (tick && cnt_reg == `DBU_START_LAST) begin
              state_reg <= RX_DATA;
              bit_reg   <= 3'h0;
            end
          end
          RX_DATA: begin
            if (samp) begin
              shift_reg <= {line, shift_reg[7:1]};
              bit_reg   <= bit_reg + 3'h1;
              if (bit_reg == 3'h7) begin
                state_reg <= par_mode[`DBU_PAR_NONE_B] ? RX_STOP : RX_PAR;
              end
            end
          end
          RX_PAR: begin
            if (samp) begin
              par_bad_reg <= line != dbu_parity(shift_reg, par_mode[1:0]);
              state_reg   <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (samp) begin
              done        <= 1'b1;
              chr.data    <= shift_reg;
              chr.par_err <= par_bad_reg && !par_mode[`DBU_PAR_NONE_B];
              chr.frm_err <= !line;
              par_bad_reg <= 1'b0;
              // A pending disable takes effect only once the stop bit is in
              state_reg   <= (stop_pend_reg || ctl.halt) ? RX_OFF : RX_IDLE;
            end
          end
          default: state_reg <= RX_OFF;
        endcase
      end
    end
  end
endmodule

// ==== dbu_top.sv ====
// Debug serial unit: APB registers, bit rate generator, transmitter, test modes, debug signals
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "dbu_map.svh"
module dbu_top import dbu_pkg::*; #(
  parameter logic [31:0] CHIP_ID = 32'h0a5a_0001, // Arbitrary value
  parameter logic [31:0] EXT_ID  = 32'h0000_0000  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  input  wire logic        emulator_channel_rx_full,
  input  wire logic        emulator_channel_tx_full,
  output logic             comm_irq,
  output logic             force_test_reset,
  output logic             rx_xfer_req,
  output logic             tx_xfer_req
);
  // Synchronisers for asynchronous inputs
  logic [1:0]    rx_pipe_reg;
  logic [1:0]    crx_pipe_reg;
  logic [1:0]    ctx_pipe_reg;
  // Configuration and state
  logic [15:0]   mode_reg;
  logic [16:0]   clock_divisor;
  logic [16:0]   pre_cnt_reg;
  logic [7:0]    rhr_reg;
  logic          receive_ready_flag_reg;
  logic          ovr_reg;
  logic          parity_error_flag_reg;
  logic          frame_reg;
  logic          tx_en_reg;
  logic          tx_dis_pend_reg;
  logic [7:0]    thr_reg;
  logic          thr_full_reg;
  dbu_tx_state_e tx_state_reg;
  logic [10:0]   tx_shift_reg;
  logic [3:0]    tx_bits_reg;
  logic [3:0]    tx_sub_reg;
  // Combinational terms
  logic          access;
  logic          wr;
  logic          rd;
  logic          tick;
  logic          tx_bit_tick;
  logic          tx_line;
  logic          rx_line;
  logic          out_next;
  logic [1:0]    chmode;
  logic [2:0]    par_mode;
  logic          wr_cr;
  logic          rst_sta;
  logic          rhr_read;
  logic          tx_load;
  logic          txrdy;
  logic          txempty;
  logic          rx_done;
  dbu_rx_char_s  rx_chr;
  dbu_rx_ctl_s   rx_ctl;
  logic [31:0]   status_word;
  logic [31:0]   rd_data;

  // Address decode, used only for the error answer; read data has its own case
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `DBU_CR_OFS, `DBU_MR_OFS, `DBU_SR_OFS, `DBU_RHR_OFS, `DBU_THR_OFS,
      `DBU_BRGR_OFS, `DBU_CIDR_OFS, `DBU_EXID_OFS, `DBU_FNR_OFS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // APB: one wait state, the write and the read side effect land on completion
  assign access = psel && penable;
  assign wr     = access && pready && pwrite;
  assign rd     = access && pready && !pwrite;
  assign wr_cr  = wr && paddr == `DBU_CR_OFS;
  assign rst_sta  = wr_cr && pwdata[`DBU_CR_RESET_STATUS_CMD];
  assign rhr_read = rd && paddr == `DBU_RHR_OFS;
  assign chmode   = mode_reg[`DBU_MR_CHM_LSB +: 2];
  assign par_mode = mode_reg[`DBU_MR_PAR_LSB +: 3];

  // Status word seen by software
  always_comb begin
    status_word                   = 32'h0000_0000;
    status_word[`DBU_SR_RECEIVE_READY_FLAG]    = receive_ready_flag_reg;
    status_word[`DBU_SR_TXRDY]    = txrdy;
    status_word[`DBU_SR_OVERRUN_FLAG]     = ovr_reg;
    status_word[`DBU_SR_FRAME]    = frame_reg;
    status_word[`DBU_SR_PARITY_ERROR_FLAG]     = parity_error_flag_reg;
    status_word[`DBU_SR_TXEMPTY]  = txempty;
    status_word[`DBU_SR_EMULATOR_CHANNEL_TX_FULL]   = ctx_pipe_reg[1];
    status_word[`DBU_SR_EMULATOR_CHANNEL_RX_FULL]   = crx_pipe_reg[1];
  end

  // Read multiplexer; write-only and unmapped locations read as zero
  always_comb begin
    case (paddr)
      `DBU_MR_OFS:   rd_data = {16'h0000, mode_reg};
      `DBU_SR_OFS:   rd_data = status_word;
      `DBU_RHR_OFS:  rd_data = {24'h000000, rhr_reg};
      `DBU_BRGR_OFS: rd_data = {15'h0000, clock_divisor};
      `DBU_CIDR_OFS: rd_data = CHIP_ID;
      `DBU_EXID_OFS: rd_data = EXT_ID;
      `DBU_FNR_OFS:  rd_data = {31'h00000000, force_test_reset};
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !is_mapped(paddr);
      if (access && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg         <= `DBU_MR_RST;
      clock_divisor    <= `DBU_DIV_RST;
      force_test_reset <= 1'b0;
    end else if (wr) begin
      if (paddr == `DBU_MR_OFS) begin
        mode_reg <= pwdata[15:0];
      end
      if (paddr == `DBU_BRGR_OFS) begin
        clock_divisor <= pwdata[16:0];
      end
      if (paddr == `DBU_FNR_OFS) begin
        force_test_reset <= pwdata[0];
      end
    end
  end

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_pipe_reg  <= 2'h3;
      crx_pipe_reg <= 2'h0;
      ctx_pipe_reg <= 2'h0;
    end else begin
      rx_pipe_reg  <= {rx_pipe_reg[0], serial_in_pin};
      crx_pipe_reg <= {crx_pipe_reg[0], emulator_channel_rx_full};
      ctx_pipe_reg <= {ctx_pipe_reg[0], emulator_channel_tx_full};
    end
  end

  // Bit rate prescaler: one sampling tick per divisor clocks
  assign tick = (clock_divisor != 17'h00000) && (pre_cnt_reg == clock_divisor - 17'h00001);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_reg <= 17'h00000;
    end else if (tick || clock_divisor == 17'h00000) begin
      pre_cnt_reg <= 17'h00000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 17'h00001;
    end
  end

  // Channel mode routing; remote loopback keeps the receiver on an idle line
  assign tx_line = tx_shift_reg[0];
  always_comb begin
    case (chmode)
      `DBU_CHM_ECHO:   begin rx_line = rx_pipe_reg[1]; out_next = rx_pipe_reg[1]; end
      `DBU_CHM_LOCAL:  begin rx_line = tx_line;        out_next = 1'b1;           end
      `DBU_CHM_REMOTE: begin rx_line = 1'b1;           out_next = rx_pipe_reg[1]; end
      default:         begin rx_line = rx_pipe_reg[1]; out_next = tx_line;        end
    endcase
  end

  // Serial output pin and debug interrupt, both registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out_pin <= 1'b1;
      comm_irq       <= 1'b0;
    end else begin
      serial_out_pin <= out_next;
      comm_irq       <= crx_pipe_reg[1] || ctx_pipe_reg[1];
    end
  end

  // Receiver commands from the control register
  assign rx_ctl.enable  = wr_cr && pwdata[`DBU_CR_RECEIVE_ENABLE_CMD];
  assign rx_ctl.halt    = wr_cr && pwdata[`DBU_CR_RECEIVE_DISABLE_CMD];
  assign rx_ctl.reset   = wr_cr && pwdata[`DBU_CR_RECEIVER_RESET_CMD];

  dbu_rx u_rx (
    .clk      (clk),
    .arst_n   (arst_n),
    .tick     (tick),
    .line     (rx_line),
    .ctl      (rx_ctl),
    .par_mode (par_mode),
    .done     (rx_done),
    .chr      (rx_chr)
  );

  // Receive holding register and sticky flags; a new event wins over a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rhr_reg   <= 8'h00;
      receive_ready_flag_reg <= 1'b0;
      ovr_reg   <= 1'b0;
      parity_error_flag_reg  <= 1'b0;
      frame_reg <= 1'b0;
    end else begin
      if (rx_done) begin
        rhr_reg   <= rx_chr.data;
        receive_ready_flag_reg <= 1'b1;
      end else if (rhr_read) begin
        receive_ready_flag_reg <= 1'b0;
      end
      if (rx_done && receive_ready_flag_reg && !rhr_read) begin
        ovr_reg <= 1'b1;
      end else if (rst_sta) begin
        ovr_reg <= 1'b0;
      end
      if (rx_done && rx_chr.par_err) begin
        parity_error_flag_reg <= 1'b1;
      end else if (rst_sta) begin
        parity_error_flag_reg <= 1'b0;
      end
      if (rx_done && rx_chr.frm_err) begin
        frame_reg <= 1'b1;
      end else if (rst_sta) begin
        frame_reg <= 1'b0;
      end
    end
  end

  // Transmitter status and transfer requests
  assign txrdy       = tx_en_reg && !thr_full_reg;
  assign txempty     = txrdy && tx_state_reg == TX_IDLE;
  assign tx_load     = tx_state_reg == TX_IDLE && thr_full_reg;
  assign tx_bit_tick = tick && tx_sub_reg == `DBU_TX_SUB_LAST;
  assign rx_xfer_req = receive_ready_flag_reg;
  assign tx_xfer_req = txrdy;

  // Transmit enable and holding register; reset command stops at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_en_reg       <= 1'b0;
      tx_dis_pend_reg <= 1'b0;
      thr_reg         <= 8'h00;
      thr_full_reg    <= 1'b0;
    end else if (wr_cr && pwdata[`DBU_CR_RSTTX]) begin
      tx_en_reg       <= 1'b0;
      tx_dis_pend_reg <= 1'b0;
      thr_full_reg    <= 1'b0;
    end else begin
      if (wr_cr && pwdata[`DBU_CR_TXEN]) begin
        tx_en_reg       <= 1'b1;
        tx_dis_pend_reg <= 1'b0;
      end else if ((wr_cr && pwdata[`DBU_CR_TXDIS]) || tx_dis_pend_reg) begin
        // Disable waits until both holding and shift registers are empty
        if (txempty || !tx_en_reg) begin
          tx_en_reg       <= 1'b0;
          tx_dis_pend_reg <= 1'b0;
        end else begin
          tx_dis_pend_reg <= 1'b1;
        end
      end
      if (wr && paddr == `DBU_THR_OFS && tx_en_reg) begin
        thr_reg      <= pwdata[7:0];
        thr_full_reg <= 1'b1;
      end else if (tx_load) begin
        thr_full_reg <= 1'b0;
      end
    end
  end

  // Transmit shifter: start, data LSB first, optional parity, stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_bits_reg  <= 4'h0;
      tx_sub_reg   <= 4'h0;
    end else if (wr_cr && pwdata[`DBU_CR_RSTTX]) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7ff;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_sub_reg <= 4'h0;
          if (tx_load) begin
            tx_state_reg <= TX_SEND;
            if (par_mode[`DBU_PAR_NONE_B]) begin
              tx_shift_reg <= {2'h3, thr_reg, 1'b0};
              tx_bits_reg  <= `DBU_TX_BITS_NOP;
            end else begin
              tx_shift_reg <= {1'b1, dbu_parity(thr_reg, par_mode[1:0]), thr_reg, 1'b0};
              tx_bits_reg  <= `DBU_TX_BITS_PAR;
            end
          end
        end
        TX_SEND: begin
          if (tick) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
          end
          if (tx_bit_tick) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_bits_reg  <= tx_bits_reg - 4'h1;
            if (tx_bits_reg == 4'h1) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end
endmodule

// ==== dbu_monitor.sv ====
// Port checker of the debug serial unit
`timescale 1ns/10ps
`include "dbu_map.svh"
module dbu_monitor #(
  parameter logic [31:0] CHIP_ID = 32'h0000_0000,
  parameter logic [31:0] EXT_ID  = 32'h0000_0000
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        emulator_channel_rx_full,
  input wire logic        emulator_channel_tx_full,
  input wire logic        comm_irq,
  input wire logic        force_test_reset,
  input wire logic        rx_xfer_req,
  input wire logic        tx_xfer_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic        rd_done;
  logic        wr_done;
  logic        mapped;
  logic [16:0] div_reg;
  // Completed transfers and the address map
  assign rd_done = psel && penable && pready && !pwrite;
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped  = paddr inside {`DBU_CR_OFS, `DBU_MR_OFS, `DBU_SR_OFS, `DBU_RHR_OFS,
    `DBU_THR_OFS, `DBU_BRGR_OFS, `DBU_CIDR_OFS, `DBU_EXID_OFS, `DBU_FNR_OFS};
  // Shadow of the divisor; while it is zero the output pin must stay high and no receive request rise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 17'h0_0000;
    end else if (wr_done && paddr == `DBU_BRGR_OFS) begin
      div_reg <= pwdata[16:0];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not one cycle after first access cycle");
  a_unmapped_err: assert property ((rd_done || wr_done) |-> (pslverr == !mapped))
    else $error("pslverr does not match the address map");
  a_div_zero_quiet: assert property (div_reg == 17'h0_0000 |-> serial_out_pin && !rx_xfer_req)
    else $error("serial port active with divisor zero");
  a_sr_rx_ready: assert property (rd_done && paddr == `DBU_SR_OFS |-> prdata[0] == $past(rx_xfer_req))
    else $error("status ready bit differs from receive request");
  a_sr_tx_ready: assert property (rd_done && paddr == `DBU_SR_OFS |-> prdata[1] == $past(tx_xfer_req))
    else $error("status tx ready bit differs from transmit request");
  a_rhr_clears: assert property (rd_done && paddr == `DBU_RHR_OFS |=> !rx_xfer_req)
    else $error("holding register read left ready set");
  a_comm_irq_delay: assert property (comm_irq == $past(emulator_channel_rx_full || emulator_channel_tx_full, 3))
    else $error("comm interrupt does not follow emulator flags");
  a_force_rst_wr: assert property (wr_done && paddr == `DBU_FNR_OFS |=> force_test_reset == $past(pwdata[0]))
    else $error("test reset output does not follow its write");
  a_chip_id_read: assert property (rd_done && paddr inside {`DBU_CIDR_OFS, `DBU_EXID_OFS}
    |-> prdata == ((paddr == `DBU_CIDR_OFS) ? CHIP_ID : EXT_ID))
    else $error("identification read wrong");
endmodule
bind dbu_top dbu_monitor #(.CHIP_ID(CHIP_ID), .EXT_ID(EXT_ID)) i_mon (.clk, .arst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .serial_in_pin,
  .serial_out_pin, .emulator_channel_rx_full, .emulator_channel_tx_full, .comm_irq,
  .force_test_reset, .rx_xfer_req, .tx_xfer_req);

// ==== dbu_term.sv ====
// Serial terminal model on the far side of the debug serial unit
`timescale 1ns/10ps
module dbu_term #(
  parameter int DIV = 2
) (
  input  wire logic clk,
  input  wire logic rx_line,
  output logic      tx_line
);
  localparam int BIT = 16 * DIV;
  initial tx_line = 1'b1;
  // Hold one bit level for a given number of clocks
  task automatic bit_out(input logic b, input int len);
    tx_line <= b;
    repeat (len) @(posedge clk);
  endtask
  // Start low, eight bits LSB first, optional parity, stop; idle high after
  task automatic send(input logic [7:0] d, input logic p, input logic use_p, input logic stp);
    int i;
    bit_out(1'b0, BIT);
    for (i = 0; i < 8; i++) bit_out(d[i], BIT);
    if (use_p) bit_out(p, BIT);
    // A broken stop bit is shortened so its tail cannot pass as a new start
    bit_out(stp, stp ? BIT : BIT * 3 / 4);
    tx_line <= 1'b1;
  endtask
  // Short low pulse on the line
  task automatic glitch(input int len);
    bit_out(1'b0, len);
    tx_line <= 1'b1;
  endtask
  // Catch one frame with parity, sampling mid-bit; ok low if no start came
  task automatic recv(output logic [7:0] d, output logic p, output logic ok);
    int i;
    logic [8:0] sh;
    ok = 1'b0;
    for (i = 0; i < 40 * BIT && !ok; i++) begin
      @(posedge clk);
      ok = !rx_line;
    end
    repeat (BIT / 2) @(posedge clk);
    for (i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk);
      sh = {rx_line, sh[8:1]};
    end
    d = sh[7:0];
    p = sh[8];
    // Move on to mid stop bit so a low parity bit is not taken as a new start
    repeat (BIT) @(posedge clk);
    ok = ok && rx_line;
  endtask
endmodule

// ==== debug_uart_baud_and_receiver_tb.sv ====
// Testbench of the debug serial unit: registers, receive, transmit and test modes
`timescale 1ns/10ps
`include "dbu_map.svh"
module debug_uart_baud_and_receiver_tb;
  localparam int          DIV = 2;
  localparam logic [31:0] CID = 32'h1234_5678; // Arbitrary value
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, e, p, ok;
  logic [7:0]  paddr, d;
  logic [31:0] pwdata, prdata, rd;
  logic        serial_in_pin, serial_out_pin, emulator_channel_rx_full;
  logic        emulator_channel_tx_full, comm_irq, force_test_reset, rx_xfer_req, tx_xfer_req;
  int          n_fail, num_checks, m;
  dbu_top #(.CHIP_ID(CID), .EXT_ID(32'h0000_0000)) i_dut (.clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .serial_in_pin, .serial_out_pin,
    .emulator_channel_rx_full, .emulator_channel_tx_full, .comm_irq, .force_test_reset,
    .rx_xfer_req, .tx_xfer_req);
  dbu_term #(.DIV(DIV)) i_term (.clk, .rx_line(serial_out_pin), .tx_line(serial_in_pin));
  // Clock
  always #5 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Status bits ready, overrun, framing and parity after a frame settles
  task automatic sr_is(input logic [31:0] exp);
    repeat (4) @(posedge clk);
    apb(1'b0, `DBU_SR_OFS, 32'h0);
    chk(rd & 32'h0000_00e1, exp);
  endtask
  function automatic logic par(input logic [7:0] v, input int md);
    return (md == 0) ? ^v : (md == 1) ? ~^v : (md == 3);
  endfunction
  initial begin
    {clk, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {emulator_channel_rx_full, emulator_channel_tx_full, n_fail, num_checks} = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, `DBU_SR_OFS, 32'h0);
    chk(rd & 32'h0000_0003, 32'h0);
    apb(1'b0, `DBU_CIDR_OFS, 32'h0);
    chk(rd, CID);
    apb(1'b0, 8'h30, 32'h0);
    chk({e, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `DBU_FNR_OFS, 32'h1);
    // The output and the two-flop flag path settle a few clocks after the edge
    emulator_channel_rx_full <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, force_test_reset}, 32'h1);
    apb(1'b0, `DBU_SR_OFS, 32'h0);
    chk({rd[31:30], 29'h0, comm_irq}, 32'h8000_0001);
    emulator_channel_rx_full <= 1'b0;
    // Divisor still zero: a frame must leave no trace
    apb(1'b1, `DBU_CR_OFS, 32'h1 << `DBU_CR_RECEIVE_ENABLE_CMD);
    i_term.send(8'h5a, 1'b0, 1'b1, 1'b1);
    sr_is(32'h0);
    apb(1'b1, `DBU_BRGR_OFS, DIV);
    i_term.send(8'ha5, 1'b0, 1'b1, 1'b1);
    sr_is(32'h1);
    apb(1'b0, `DBU_RHR_OFS, 32'h0);
    chk(rd & 32'hff, 32'ha5);
    sr_is(32'h0);
    // Bad parity and low stop, then a second frame unread
    i_term.send(8'h0f, 1'b1, 1'b1, 1'b0);
    sr_is(32'hc1);
    i_term.send(8'h33, 1'b0, 1'b1, 1'b1);
    sr_is(32'he1);
    apb(1'b0, `DBU_RHR_OFS, 32'h0);
    chk(rd & 32'hff, 32'h33);
    apb(1'b1, `DBU_CR_OFS, 32'h1 << `DBU_CR_RESET_STATUS_CMD);
    sr_is(32'h0);
    i_term.glitch(6 * DIV);
    repeat (400) @(posedge clk);
    sr_is(32'h0);
    apb(1'b1, `DBU_CR_OFS, 32'h1 << `DBU_CR_RECEIVE_DISABLE_CMD);
    i_term.send(8'h44, 1'b0, 1'b1, 1'b1);
    sr_is(32'h0);
    apb(1'b1, `DBU_CR_OFS, 32'h1 << `DBU_CR_RECEIVE_ENABLE_CMD);
    fork
      i_term.send(8'h11, 1'b1, 1'b1, 1'b1);
      begin
        repeat (100) @(posedge clk);
        apb(1'b1, `DBU_CR_OFS, 32'h1 << `DBU_CR_RECEIVER_RESET_CMD);
      end
    join
    sr_is(32'h0);
    apb(1'b1, `DBU_CR_OFS, 32'h1 << `DBU_CR_RECEIVE_ENABLE_CMD | 32'h1 << `DBU_CR_TXEN);
    // Even, odd, space and mark parity on the transmit pin
    for (m = 0; m < 4; m++) begin
      apb(1'b1, `DBU_MR_OFS, m << `DBU_MR_PAR_LSB);
      fork
        i_term.recv(d, p, ok);
        apb(1'b1, `DBU_THR_OFS, 32'h96 ^ m);
      join
      chk({ok, p, d}, {1'b1, par(8'h96 ^ m, m), 8'h96 ^ m[7:0]});
    end
    // Local loopback: receiver hears the transmitter, pin stays idle
    apb(1'b1, `DBU_MR_OFS, 32'h2 << `DBU_MR_CHM_LSB);
    apb(1'b1, `DBU_THR_OFS, 32'h69);
    repeat (450) @(posedge clk);
    chk({31'h0, serial_out_pin}, 32'h1);
    apb(1'b0, `DBU_RHR_OFS, 32'h0);
    chk(rd & 32'hff, 32'h69);
    // Echo and remote loopback: the pin repeats the line; only echo feeds the receiver
    for (m = 1; m < 4; m += 2) begin
      apb(1'b1, `DBU_MR_OFS, m << `DBU_MR_CHM_LSB);
      fork
        i_term.recv(d, p, ok);
        i_term.send(8'h5c ^ m[7:0], par(8'h5c ^ m[7:0], 0), 1'b1, 1'b1);
      join
      chk({ok, p, d}, {1'b1, par(8'h5c ^ m[7:0], 0), 8'h5c ^ m[7:0]});
      sr_is((m == 1) ? 32'h1 : 32'h0);
      apb(1'b0, `DBU_RHR_OFS, 32'h0);
    end
    end_sim();
  end
endmodule
